// file: rtl/citd_consts.vh
// constants for the instruction timing decoder
`ifndef CITD_CONSTS_VH
`define CITD_CONSTS_VH
`define CITD_OP_NOP        8'h00
`define CITD_OP_UNUSED     8'ha5
`define CITD_OP_LONG_JUMP  8'h02
`define CITD_OP_LONG_CALL  8'h12
`define CITD_OP_RET        8'h22
`define CITD_OP_IRET       8'h32
`define CITD_OP_SHORT      8'h80
`define CITD_OP_JMP_IND    8'h73
`define CITD_OP_CODE_PC    8'h83
`define CITD_OP_CODE_DP    8'h93
`define CITD_OP_LOAD_DP    8'h90
`define CITD_OP_MOV_DD     8'h85
`define CITD_OP_BTC        8'h10
`define CITD_OP_JB         8'h20
`define CITD_OP_JNB        8'h30
`define CITD_OP_JC         8'h40
`define CITD_OP_JNC        8'h50
`define CITD_OP_AZ         8'h60
`define CITD_OP_ANZ        8'h70
`define CITD_OP_MUL        8'ha4
`define CITD_OP_DIV        8'h84
`define CITD_OP_INC_DP     8'ha3
`define CITD_OP_CMP_AD     8'hb5
`define CITD_OP_CMP_AI     8'hb4
`define CITD_OP_DEC_BR_D   8'hd5
`define CITD_STATUS_BANK_LO 3
`define CITD_STATUS_BANK_HI 4
`define CITD_SFR_BIT       7
`define CITD_MISS_CYCLES   4'h2
`endif

// file: rtl/citd_branch_cache.v
// small direct-mapped branch target tag store
`timescale 1ns/1ps
module citd_branch_cache
#(
   parameter IDX_W = 4,
   parameter TAG_W = 12
)
(
   input  wire             clk,
   input  wire             resetn,
   input  wire [IDX_W-1:0] lookup_idx,
   input  wire [TAG_W-1:0] lookup_tag,
   input  wire             fill,
   output reg              hit_ff
);
   localparam DEPTH = 1 << IDX_W;
   reg [TAG_W-1:0] tag_mem [0:DEPTH-1];
   reg [DEPTH-1:0] valid_ff;

   always @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         valid_ff <= {DEPTH{1'b0}};
         hit_ff   <= 1'b0;
      end
      else
      begin
         hit_ff <= valid_ff[lookup_idx] && (tag_mem[lookup_idx] == lookup_tag);
         if (fill)
            valid_ff[lookup_idx] <= 1'b1;
      end
   end

   always @(posedge clk)
   begin
      if (fill)
         tag_mem[lookup_idx] <= lookup_tag;
   end
endmodule // citd_branch_cache

// file: rtl/citd_decoder.v
// instruction length, cycle timing and operand address decoder
`timescale 1ns/1ps
`include "citd_consts.vh"

// Summary of operation
// (RL1) external data moves: one byte, 3 clocks
// (RL2) code byte moves: one byte, 3 clocks
// (RL3) low nibble exchange: one byte, 2 clocks
// (RL4) load data pointer immediate: 3 bytes, 3
// (RL5) logic immediate to direct: 3 bytes, 3
// (RL6) direct to direct move: 3 bytes, 3
// (RL7) compare indirect branch: 3 bytes, 4/5
// (RL8) compare acc/register branch: 3 bytes, 3/4
// (RL9) decrement branch: register 2/3, direct 3/4
// (RL10) bit test clear: jump if set, clear bit
// (RL11) acc zero/nonzero branches: 2 bytes, 2/3
// (RL12) indirect jump to acc plus pointer
// (RL13) short jump 3, long 4, returns 5
// (RL14) rel is signed offset from next
// (RL15) paged target stays in 2K page
// (RL16) full target reaches whole 64K space
// (RL17) cache miss adds penalty cycles
// (RL18) unused opcode behaves as no-op
// (RL19) direct below 0x80 RAM, else SPECIAL_FUNCTION_SPACE
// (RL20) bank register selects one of eight
// (RL21) indirect uses R0 or R1 of bank
// (RL22) carry bit logic: 2 bytes, 2 clocks
// (RL23) cycles usually equal byte count
// (RL24) untaken branch one clock less
// (RL25) bank chosen by status bits 3, 4
module citd_decoder
#(
   parameter IDX_W = 4,
   parameter TAG_W = 12
)
(
   input  wire        CLK,
   input  wire        RESETN,
   input  wire        INSTR_VALID,
   input  wire [7:0]  OPCODE,
   input  wire [7:0]  OPERAND1,
   input  wire [7:0]  OPERAND2,
   input  wire [15:0] PC,
   input  wire [7:0]  ACC,
   input  wire [15:0] DATA_POINTER,
   input  wire [7:0]  PROGRAM_STATUS_WORD,
   input  wire        CARRY,
   input  wire        BIT_VALUE,
   input  wire [7:0]  CMP_VALUE,
   input  wire [7:0]  DEC_VALUE,
   output reg  [1:0]  LENGTH,
   output reg  [3:0]  CYCLES,
   output reg         IS_BRANCH,
   output reg         TAKEN,
   output reg         CACHE_MISS,
   output reg  [15:0] TARGET,
   output reg  [7:0]  DIRECT_ADDR,
   output reg         DIRECT_IS_SFR,
   output reg  [4:0]  BANK_REG_ADDR,
   output reg  [4:0]  INDIRECT_PTR_ADDR,
   output reg         BIT_CLEAR,
   output reg         NIBBLE_ONLY,
   output reg         IS_NOP,
   output reg         DONE
);
   reg  [1:0]  nxt_len;
   reg  [3:0]  nxt_cyc;
   reg         nxt_br;
   reg         nxt_taken;
   reg  [15:0] nxt_tgt;
   reg         nxt_cond;
   wire [15:0] next_pc;
   wire [15:0] rel_off;
   wire [7:0]  rel_byte;
   wire [1:0]  bank;
   wire        hit;
   wire        op_ext_move;
   wire        op_cmp_reg;
   wire        op_cmp_ind;
   wire        op_dec_reg;
   wire        op_paged;
   wire        op_bitlogic;
   wire        op_logic_imm;
   reg  [3:0]  busy_ff;
   reg         pend_ff;

   assign bank = {PROGRAM_STATUS_WORD[`CITD_STATUS_BANK_HI],
                  PROGRAM_STATUS_WORD[`CITD_STATUS_BANK_LO]};   // [RL25]
   assign next_pc = PC + {14'h0000, nxt_len};
   // relative byte sits last in three-byte forms
   assign rel_byte = (nxt_len == 2'h3) ? OPERAND2 : OPERAND1;
   assign rel_off = {{8{rel_byte[7]}}, rel_byte};         // [RL14]

   assign op_ext_move = (OPCODE == 8'he0) || (OPCODE == 8'hf0) ||
                        (OPCODE[7:5] == 3'h7 && OPCODE[3:1] == 3'h1);
   assign op_cmp_reg   = (OPCODE[7:3] == 5'h17);
   assign op_cmp_ind   = (OPCODE[7:1] == 7'h5b);
   assign op_dec_reg   = (OPCODE[7:3] == 5'h1b);
   assign op_paged     = (OPCODE[3:0] == 4'h1);
   assign op_bitlogic  = (OPCODE == 8'h82) || (OPCODE == 8'hb0) ||
                         (OPCODE == 8'h72) || (OPCODE == 8'ha0);
   assign op_logic_imm = (OPCODE == 8'h53) || (OPCODE == 8'h43) ||
                         (OPCODE == 8'h63);

   always @*
   begin
      nxt_len   = 2'h1;
      nxt_cyc   = 4'h1;
      nxt_br    = 1'b0;
      nxt_cond  = 1'b0;
      nxt_taken = 1'b0;
      if (op_ext_move)
         nxt_cyc = 4'h3;                                   // [RL1]
      else if (OPCODE == `CITD_OP_CODE_PC || OPCODE == `CITD_OP_CODE_DP)
         nxt_cyc = 4'h3;                                   // [RL2]
      else if (OPCODE[7:1] == 7'h6b)
         nxt_cyc = 4'h2;                                   // [RL3]
      else if (OPCODE == `CITD_OP_LOAD_DP)
      begin
         nxt_len = 2'h3;                                   // [RL4]
         nxt_cyc = 4'h3;
      end
      else if (op_logic_imm || OPCODE == `CITD_OP_MOV_DD ||
               OPCODE == 8'h75)
      begin
         nxt_len = 2'h3;                                   // [RL5] [RL6]
         nxt_cyc = 4'h3;
      end
      else if (op_cmp_ind)
      begin
         nxt_len  = 2'h3;
         nxt_cyc  = 4'h4;                                  // [RL7]
         nxt_br   = 1'b1;
         nxt_cond = 1'b1;
         nxt_taken = (CMP_VALUE != OPERAND1);
      end
      else if (op_cmp_reg || OPCODE == `CITD_OP_CMP_AD ||
               OPCODE == `CITD_OP_CMP_AI)
      begin
         nxt_len  = 2'h3;
         nxt_cyc  = 4'h3;                                  // [RL8]
         nxt_br   = 1'b1;
         nxt_cond = 1'b1;
         nxt_taken = (OPCODE == `CITD_OP_CMP_AD) ? (ACC != CMP_VALUE) :
                     (OPCODE == `CITD_OP_CMP_AI) ? (ACC != OPERAND1) :
                     (CMP_VALUE != OPERAND1);
      end
      else if (op_dec_reg || OPCODE == `CITD_OP_DEC_BR_D)
      begin
         nxt_len  = op_dec_reg ? 2'h2 : 2'h3;              // [RL9]
         nxt_cyc  = op_dec_reg ? 4'h2 : 4'h3;
         nxt_br   = 1'b1;
         nxt_cond = 1'b1;
         nxt_taken = (DEC_VALUE != 8'h01);
      end
      else if (OPCODE == `CITD_OP_BTC || OPCODE == `CITD_OP_JB ||
               OPCODE == `CITD_OP_JNB)
      begin
         nxt_len  = 2'h3;
         nxt_cyc  = 4'h3;                                  // [RL10]
         nxt_br   = 1'b1;
         nxt_cond = 1'b1;
         nxt_taken = (OPCODE == `CITD_OP_JNB) ? !BIT_VALUE : BIT_VALUE;
      end
      else if (OPCODE == `CITD_OP_AZ || OPCODE == `CITD_OP_ANZ ||
               OPCODE == `CITD_OP_JC || OPCODE == `CITD_OP_JNC)
      begin
         nxt_len  = 2'h2;
         nxt_cyc  = 4'h2;                                  // [RL11]
         nxt_br   = 1'b1;
         nxt_cond = 1'b1;
         case (OPCODE)
            `CITD_OP_AZ:  nxt_taken = (ACC == 8'h00);
            `CITD_OP_ANZ: nxt_taken = (ACC != 8'h00);
            `CITD_OP_JC:  nxt_taken = CARRY;
            default:      nxt_taken = !CARRY;
         endcase
      end
      else if (OPCODE == `CITD_OP_JMP_IND)
      begin
         nxt_cyc   = 4'h3;                                 // [RL12]
         nxt_br    = 1'b1;
         nxt_taken = 1'b1;
      end
      else if (OPCODE == `CITD_OP_SHORT || op_paged)
      begin
         nxt_len   = 2'h2;
         nxt_cyc   = 4'h3;                                 // [RL13]
         nxt_br    = 1'b1;
         nxt_taken = 1'b1;
      end
      else if (OPCODE == `CITD_OP_LONG_JUMP || OPCODE == `CITD_OP_LONG_CALL)
      begin
         nxt_len   = 2'h3;
         nxt_cyc   = 4'h4;                                 // [RL13]
         nxt_br    = 1'b1;
         nxt_taken = 1'b1;
      end
      else if (OPCODE == `CITD_OP_RET || OPCODE == `CITD_OP_IRET)
      begin
         nxt_cyc   = 4'h5;                                 // [RL13]
         nxt_br    = 1'b1;
         nxt_taken = 1'b1;
      end
      else if (op_bitlogic)
      begin
         nxt_len = 2'h2;                                   // [RL22]
         nxt_cyc = 4'h2;
      end
      else if (OPCODE == `CITD_OP_MUL)
         nxt_cyc = 4'h4;
      else if (OPCODE == `CITD_OP_DIV)
         nxt_cyc = 4'h8;
      else if (OPCODE == `CITD_OP_NOP || OPCODE == `CITD_OP_UNUSED ||
               OPCODE == `CITD_OP_INC_DP)
         nxt_cyc = 4'h1;                                   // [RL18]
      else
      begin
         // remaining forms: one cycle per byte, indirect takes two
         nxt_len = (OPCODE[3:0] == 4'h5 || OPCODE[3:0] == 4'h4 ||
                    OPCODE[3:0] == 4'h2 || OPCODE[7:3] == 5'h15) ?
                   2'h2 : 2'h1;
         if (OPCODE == 8'he4 || OPCODE == 8'hc4 || OPCODE == 8'hd4 ||
             OPCODE == 8'hf4 || OPCODE[7:4] == 4'hc || OPCODE[3:0] == 4'h3)
            nxt_len = 2'h1;
         nxt_cyc = {2'h0, nxt_len};                        // [RL23]
         if (OPCODE[3:1] == 3'h3)
            nxt_cyc = 4'h2;
      end
      if (nxt_cond && nxt_taken)
         nxt_cyc = nxt_cyc + 4'h1;                         // [RL24]
   end

   always @*
   begin
      if (OPCODE == `CITD_OP_JMP_IND)
         nxt_tgt = {8'h00, ACC} + DATA_POINTER;            // [RL12]
      else if (OPCODE == `CITD_OP_LONG_JUMP || OPCODE == `CITD_OP_LONG_CALL)
         nxt_tgt = {OPERAND1, OPERAND2};                   // [RL16]
      else if (op_paged)
         nxt_tgt = {next_pc[15:11], OPCODE[7:5], OPERAND1}; // [RL15]
      else
         nxt_tgt = next_pc + rel_off;                      // [RL14]
   end

   citd_branch_cache
   #(
      .IDX_W (IDX_W),
      .TAG_W (TAG_W)
   )
   u_cache
   (
      .clk        (CLK),
      .resetn     (RESETN),
      .lookup_idx (nxt_tgt[IDX_W-1:0]),
      .lookup_tag (nxt_tgt[TAG_W+IDX_W-1:IDX_W]),
      .fill       (INSTR_VALID && busy_ff == 4'h0 && nxt_br && nxt_taken),
      .hit_ff     (hit)
   );

   always @(posedge CLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         LENGTH            <= 2'h0;
         CYCLES            <= 4'h0;
         IS_BRANCH         <= 1'b0;
         TAKEN             <= 1'b0;
         CACHE_MISS        <= 1'b0;
         TARGET            <= 16'h0000;
         DIRECT_ADDR       <= 8'h00;
         DIRECT_IS_SFR     <= 1'b0;
         BANK_REG_ADDR     <= 5'h00;
         INDIRECT_PTR_ADDR <= 5'h00;
         BIT_CLEAR         <= 1'b0;
         NIBBLE_ONLY       <= 1'b0;
         IS_NOP            <= 1'b0;
         DONE              <= 1'b0;
         busy_ff           <= 4'h0;
         pend_ff           <= 1'b0;
      end
      else
      begin
         DONE       <= (busy_ff == 4'h1);
         CACHE_MISS <= 1'b0;
         pend_ff    <= 1'b0;
         if (busy_ff != 4'h0)
            busy_ff <= busy_ff - 4'h1;
         if (pend_ff && !hit)
         begin
            CACHE_MISS <= 1'b1;                            // [RL17]
            CYCLES     <= CYCLES + `CITD_MISS_CYCLES;
            busy_ff    <= busy_ff + `CITD_MISS_CYCLES - 4'h1;
         end
         if (INSTR_VALID && busy_ff == 4'h0)
         begin
            LENGTH        <= nxt_len;
            CYCLES        <= nxt_cyc;
            IS_BRANCH     <= nxt_br;
            TAKEN         <= nxt_taken;
            TARGET        <= nxt_taken ? nxt_tgt : next_pc;
            pend_ff       <= nxt_br && nxt_taken;
            busy_ff       <= nxt_cyc;
            DIRECT_ADDR   <= OPERAND1;
            DIRECT_IS_SFR <= OPERAND1[`CITD_SFR_BIT];      // [RL19]
            BANK_REG_ADDR <= {bank, OPCODE[2:0]};          // [RL20]
            INDIRECT_PTR_ADDR <= {bank, 2'h0, OPCODE[0]};  // [RL21]
            BIT_CLEAR     <= (OPCODE == `CITD_OP_BTC) && BIT_VALUE; // [RL10]
            NIBBLE_ONLY   <= (OPCODE[7:1] == 7'h6b);       // [RL3]
            IS_NOP        <= (OPCODE == `CITD_OP_NOP) ||
                             (OPCODE == `CITD_OP_UNUSED);  // [RL18]
         end
      end
   end
endmodule // citd_decoder

// file: tb/citd_props.sv
// port assertions for the instruction timing decoder
`timescale 1ns/1ps
module citd_props
(
   input wire        CLK,
   input wire        RESETN,
   input wire        INSTR_VALID,
   input wire [7:0]  OPCODE,
   input wire [7:0]  OPERAND1,
   input wire [7:0]  OPERAND2,
   input wire [15:0] PC,
   input wire [7:0]  PROGRAM_STATUS_WORD,
   input wire [1:0]  LENGTH,
   input wire [3:0]  CYCLES,
   input wire        IS_BRANCH,
   input wire        TAKEN,
   input wire        CACHE_MISS,
   input wire [15:0] TARGET,
   input wire [7:0]  DIRECT_ADDR,
   input wire        DIRECT_IS_SFR,
   input wire [4:0]  BANK_REG_ADDR,
   input wire        BIT_CLEAR,
   input wire        NIBBLE_ONLY,
   input wire        IS_NOP,
   input wire        DONE
);
   reg        idle_ff;
   reg  [3:0] cnt_ff;
   // a new instruction is taken when idle or in the cycle of done
   wire       acc_w = INSTR_VALID && (idle_ff || DONE);
   wire [15:0] nxt2  = PC + 16'h0002;
   wire [15:0] rel_t = nxt2 + {{8{OPERAND1[7]}}, OPERAND1};
   wire [15:0] pg_t  = {nxt2[15:11], OPCODE[7:5], OPERAND1};
   always @(posedge CLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         idle_ff <= 1'b1;
         cnt_ff  <= 4'h0;
      end
      else
      begin
         idle_ff <= acc_w ? 1'b0 : (DONE ? 1'b1 : idle_ff);
         cnt_ff  <= acc_w ? 4'h0 : cnt_ff + 4'h1;
      end
   end
   sequence s_acc(logic [7:0] o);
      acc_w && OPCODE == o;
   endsequence
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RESETN);
   a_done_count: assert property (DONE |-> cnt_ff == CYCLES)
      else $error("done not at cycle count");
   a_done_pulse: assert property (DONE |=> !DONE)
      else $error("done wider than one cycle");
   a_miss_pulse: assert property (CACHE_MISS |=> !CACHE_MISS)
      else $error("miss wider than one cycle");
   a_sfr_split: assert property (DIRECT_IS_SFR == DIRECT_ADDR[7])
      else $error("direct space select wrong");
   a_nop_short: assert property (IS_NOP |-> LENGTH == 2'h1 && CYCLES == 4'h1)
      else $error("unused opcode not like nop");
   a_nibble_len: assert property (NIBBLE_ONLY |-> LENGTH == 2'h1 && CYCLES == 4'h2)
      else $error("nibble exchange timing wrong");
   a_clear_taken: assert property (BIT_CLEAR |-> TAKEN && IS_BRANCH)
      else $error("bit clear without taken branch");
   a_long_target: assert property (s_acc(8'h02) |=> LENGTH == 2'h3 && TARGET == {$past(OPERAND1), $past(OPERAND2)})
      else $error("long target wrong");
   a_rel_target: assert property (s_acc(8'h80) |=> TAKEN && TARGET == $past(rel_t))
      else $error("relative target wrong");
   a_paged_target: assert property (acc_w && OPCODE[4:0] == 5'h01 |=> TARGET == $past(pg_t))
      else $error("paged target wrong");
   a_bank_sel: assert property (acc_w && OPCODE[7:3] == 5'h1d |=> BANK_REG_ADDR == {$past(PROGRAM_STATUS_WORD[4:3]), $past(OPCODE[2:0])})
      else $error("bank register address wrong");
endmodule // citd_props

// file: tb/citd_decoder_tb.sv
// self-checking bench for the instruction timing decoder
`timescale 1ns/1ps
`include "citd_consts.vh"
module citd_decoder_tb;
   reg         clk = 1'b0;
   reg         resetn = 1'b0;
   reg         iv = 1'b0;
   reg  [7:0]  op = 8'h00;
   reg  [7:0]  o1 = 8'h00;
   reg  [7:0]  o2 = 8'h00;
   reg  [15:0] pc = 16'h0000;
   reg  [7:0]  acc = 8'h00;
   reg  [7:0]  program_status_word = 8'h00;
   reg         bv = 1'b0;
   reg  [7:0]  cmp = 8'h00;
   reg  [7:0]  dec = 8'h00;
   reg         cy = 1'b0;
   integer     err_total = 0;
   integer     num_checks = 0;
   integer     tick = 0;
   integer     i;
   wire [1:0]  LENGTH;
   wire [3:0]  CYCLES;
   wire        IS_BRANCH, TAKEN, CACHE_MISS, DIRECT_IS_SFR;
   wire        BIT_CLEAR, NIBBLE_ONLY, IS_NOP, DONE;
   wire [15:0] TARGET;
   wire [7:0]  DIRECT_ADDR;
   wire [4:0]  BANK_REG_ADDR, INDIRECT_PTR_ADDR;
   citd_decoder citd_decoder_i (.CLK(clk), .RESETN(resetn),
      .INSTR_VALID(iv), .OPCODE(op), .OPERAND1(o1), .OPERAND2(o2),
      .PC(pc), .ACC(acc), .DATA_POINTER(16'h3000),
      .PROGRAM_STATUS_WORD(program_status_word), .CARRY(cy), .BIT_VALUE(bv),
      .CMP_VALUE(cmp), .DEC_VALUE(dec), .LENGTH(LENGTH), .CYCLES(CYCLES),
      .IS_BRANCH(IS_BRANCH), .TAKEN(TAKEN), .CACHE_MISS(CACHE_MISS),
      .TARGET(TARGET), .DIRECT_ADDR(DIRECT_ADDR),
      .DIRECT_IS_SFR(DIRECT_IS_SFR), .BANK_REG_ADDR(BANK_REG_ADDR),
      .INDIRECT_PTR_ADDR(INDIRECT_PTR_ADDR), .BIT_CLEAR(BIT_CLEAR),
      .NIBBLE_ONLY(NIBBLE_ONLY), .IS_NOP(IS_NOP), .DONE(DONE));
   always #5 clk = ~clk;
   task end_sim;
   begin
      $display("checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   end
   endtask
   task chk(input [15:0] g, input [15:0] e);
   begin
      num_checks = num_checks + 1;
      if (g !== e)
      begin
         err_total = err_total + 1;
         $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
      end
   end
   endtask
   task setv(input [7:0] a, c, d, input b, input [7:0] s);
   begin
      @(posedge clk);
      acc <= a;
      cmp <= c;
      dec <= d;
      bv <= b;
      program_status_word <= s;
   end
   endtask
   // tk: 0 falls through, 1 taken, 2 unchecked; mm: 0 hit, 1 miss, 2 any
   task run(input [7:0] p, a, b, input [15:0] q, input [1:0] len,
            input [3:0] c, input [1:0] tk, input [15:0] tgt,
            input [1:0] mm);
      integer   n;
      reg       ms;
      reg [3:0] e;
   begin
      @(posedge clk);
      op <= p;
      o1 <= a;
      o2 <= b;
      pc <= q;
      iv <= 1'b1;
      @(posedge clk);
      iv <= 1'b0;
      n = 0;
      ms = 1'b0;
      while (DONE !== 1'b1 && n < 20)
      begin
         @(posedge clk);
         #1;
         n = n + 1;
         ms = ms | (CACHE_MISS === 1'b1);
      end
      e = c + (ms ? `CITD_MISS_CYCLES : 4'h0);
      chk(LENGTH, len);
      chk(CYCLES, e);
      chk(n[15:0], e);
      if (mm < 2)
         chk(ms, mm[0]);
      if (tk < 2)
      begin
         chk(TAKEN, tk[0]);
         chk(IS_BRANCH, 1'b1);
         chk(TARGET, tgt);
      end
   end
   endtask
   // a taken branch misses on a new target, then hits on repeat
   task br2(input [7:0] p, a, b, input [15:0] q, input [1:0] len,
            input [3:0] c, input [15:0] tgt);
   begin
      run(p, a, b, q, len, c, 2'd1, tgt, 2'd1);
      run(p, a, b, q, len, c, 2'd1, tgt, 2'd0);
   end
   endtask
   task run4(input [31:0] ops, input [1:0] len, input [3:0] c);
      integer k;
   begin
      for (k = 0; k < 4; k = k + 1)
         run(ops[8*k+:8], 8'h7f, 8'h00, 16'h0100, len, c, 2'd2, 16'h0, 2'd0);
   end
   endtask
   task t_fixed;
   begin
      run4(32'he0e2f0f3, 2'd1, 4'h3);
      run4(32'h93839383, 2'd1, 4'h3);
      run4(32'h90859085, 2'd3, 4'h3);
      run4(32'h53436353, 2'd3, 4'h3);
      run4(32'h82b072a0, 2'd2, 4'h2);
      run4(32'h00a500a5, 2'd1, 4'h1);
      chk(IS_NOP, 1'b1);
      chk(IS_BRANCH, 1'b0);
      run4(32'hd6d7d6d7, 2'd1, 4'h2);
      chk(NIBBLE_ONLY, 1'b1);
      chk(IS_NOP, 1'b0);
   end
   endtask
   task t_branch;
   begin
      setv(8'h00, 8'h44, 8'h01, 1'b1, 8'h00);
      br2(8'h60, 8'hf0, 8'h00, 16'h1000, 2'd2, 4'h3, 16'h0ff2);
      run(8'h70, 8'hf0, 8'h00, 16'h1000, 2'd2, 4'h2, 2'd0, 16'h1002, 2'd2);
      br2(8'h80, 8'h7f, 8'h00, 16'h1000, 2'd2, 4'h3, 16'h1081);
      br2(8'h02, 8'hfe, 8'hdc, 16'h0010, 2'd3, 4'h4, 16'hfedc);
      br2(8'h12, 8'hab, 8'hcd, 16'h0010, 2'd3, 4'h4, 16'habcd);
      br2(8'he1, 8'h34, 8'h00, 16'h27fe, 2'd2, 4'h3, 16'h2f34);
      br2(8'hf1, 8'h00, 8'h00, 16'h4000, 2'd2, 4'h3, 16'h4700);
      run(8'h22, 8'h00, 8'h00, 16'h0200, 2'd1, 4'h5, 2'd2, 16'h0, 2'd2);
      run(8'h32, 8'h00, 8'h00, 16'h0200, 2'd1, 4'h5, 2'd2, 16'h0, 2'd2);
      br2(8'h10, 8'h20, 8'h80, 16'h7000, 2'd3, 4'h4, 16'h6f83);
      chk(BIT_CLEAR, 1'b1);
      run(8'hd8, 8'h20, 8'h00, 16'h6000, 2'd2, 4'h2, 2'd0, 16'h6002, 2'd2);
      run(8'hd5, 8'h30, 8'h20, 16'h6100, 2'd3, 4'h3, 2'd0, 16'h6103, 2'd2);
      run(8'hb6, 8'h44, 8'h10, 16'h5000, 2'd3, 4'h4, 2'd0, 16'h5003, 2'd2);
      run(8'hb8, 8'h44, 8'h10, 16'h5100, 2'd3, 4'h3, 2'd0, 16'h5103, 2'd2);
      setv(8'h10, 8'h45, 8'h03, 1'b0, 8'h00);
      run(8'hb4, 8'h10, 8'h10, 16'h5200, 2'd3, 4'h3, 2'd0, 16'h5203, 2'd2);
      br2(8'h73, 8'h00, 8'h00, 16'h2000, 2'd1, 4'h3, 16'h3010);
      br2(8'hb6, 8'h44, 8'h10, 16'h5000, 2'd3, 4'h5, 16'h5013);
      br2(8'hb8, 8'h44, 8'h10, 16'h5100, 2'd3, 4'h4, 16'h5113);
      br2(8'hb4, 8'h11, 8'h10, 16'h5200, 2'd3, 4'h4, 16'h5213);
      br2(8'hd8, 8'h20, 8'h00, 16'h6000, 2'd2, 4'h3, 16'h6022);
      br2(8'hd5, 8'h30, 8'h20, 16'h6100, 2'd3, 4'h4, 16'h6123);
      run(8'h10, 8'h20, 8'h80, 16'h7000, 2'd3, 4'h3, 2'd0, 16'h7003, 2'd2);
      chk(BIT_CLEAR, 1'b0);
      run(8'h40, 8'h10, 8'h00, 16'h0400, 2'd2, 4'h2, 2'd0, 16'h0402, 2'd2);
      run(8'h50, 8'h10, 8'h00, 16'h0400, 2'd2, 4'h3, 2'd1, 16'h0412, 2'd2);
      @(posedge clk);
      cy <= 1'b1;
      run(8'h40, 8'h10, 8'h00, 16'h0500, 2'd2, 4'h3, 2'd1, 16'h0512, 2'd2);
      run(8'h50, 8'h10, 8'h00, 16'h0500, 2'd2, 4'h2, 2'd0, 16'h0502, 2'd2);
   end
   endtask
   task t_addr;
   begin
      for (i = 0; i < 4; i = i + 1)
      begin
         setv(8'h00, 8'h00, 8'h00, 1'b0, {3'h0, i[1:0], 3'h0});
         run(8'hec, 8'h00, 8'h00, 16'h0300, 2'd1, 4'h1, 2'd2, 16'h0, 2'd0);
         chk(BANK_REG_ADDR, {i[1:0], 3'h4});
         run(8'he7, 8'h00, 8'h00, 16'h0300, 2'd1, 4'h2, 2'd2, 16'h0, 2'd0);
         chk(INDIRECT_PTR_ADDR, {i[1:0], 3'h1});
      end
      run(8'h53, 8'h7f, 8'h0f, 16'h0300, 2'd3, 4'h3, 2'd2, 16'h0, 2'd0);
      chk({DIRECT_IS_SFR, DIRECT_ADDR}, 16'h007f);
      run(8'h53, 8'h80, 8'h0f, 16'h0300, 2'd3, 4'h3, 2'd2, 16'h0, 2'd0);
      chk({DIRECT_IS_SFR, DIRECT_ADDR}, 16'h0180);
   end
   endtask
   always @(posedge clk)
   begin
      tick <= tick + 1;
      if (tick == 4000)
      begin
         err_total = err_total + 1;
         end_sim;
      end
   end
   initial
   begin
      repeat (20) @(posedge clk);
      resetn <= 1'b1;
      t_fixed;
      t_branch;
      t_addr;
      end_sim;
   end
endmodule // citd_decoder_tb
bind citd_decoder citd_props citd_props_i (.CLK(CLK), .RESETN(RESETN),
   .INSTR_VALID(INSTR_VALID), .OPCODE(OPCODE), .OPERAND1(OPERAND1),
   .OPERAND2(OPERAND2), .PC(PC), .PROGRAM_STATUS_WORD(PROGRAM_STATUS_WORD),
   .LENGTH(LENGTH), .CYCLES(CYCLES), .IS_BRANCH(IS_BRANCH), .TAKEN(TAKEN),
   .CACHE_MISS(CACHE_MISS), .TARGET(TARGET), .DIRECT_ADDR(DIRECT_ADDR),
   .DIRECT_IS_SFR(DIRECT_IS_SFR), .BANK_REG_ADDR(BANK_REG_ADDR),
   .BIT_CLEAR(BIT_CLEAR), .NIBBLE_ONLY(NIBBLE_ONLY), .IS_NOP(IS_NOP),
   .DONE(DONE));
